// file: design/mcu14_pkg.sv
// Package of constants and types for the 14-bit instruction core.
package mcu14_pkg;
   // Oscillator periods in one instruction cycle.
   localparam int unsigned CLOCKS_PER_CYCLE = 4;
   localparam logic [12:0] RESET_PC = 13'h0000;

   typedef struct packed {
      logic timeout_flag;
      logic powerdown_flag;
      logic z;
      logic digit_carry;
      logic c;
   } mcu14_status_s;
   localparam mcu14_status_s STATUS_RESET = 5'h18;

   // Instruction groups in bits 13:12.
   localparam logic [1:0] GRP_BYTE = 2'h0;
   localparam logic [1:0] GRP_BIT = 2'h1;
   localparam logic [1:0] GRP_JUMP = 2'h2;
   localparam logic [1:0] GRP_LIT = 2'h3;

   // Byte-oriented operation codes in bits 11:8.
   localparam logic [3:0] OP_MISC = 4'h0;
   localparam logic [3:0] OP_CLR = 4'h1;
   localparam logic [3:0] OP_SUB = 4'h2;
   localparam logic [3:0] OP_DEC = 4'h3;
   localparam logic [3:0] OP_IOR = 4'h4;
   localparam logic [3:0] OP_AND = 4'h5;
   localparam logic [3:0] OP_XOR = 4'h6;
   localparam logic [3:0] OP_ADD = 4'h7;
   localparam logic [3:0] OP_MOVE = 4'h8;
   localparam logic [3:0] OP_COMPL = 4'h9;
   localparam logic [3:0] OP_INC = 4'ha;
   localparam logic [3:0] OP_DECSZ = 4'hb;
   localparam logic [3:0] OP_ROR = 4'hc;
   localparam logic [3:0] OP_ROL = 4'hd;
   localparam logic [3:0] OP_SWAP = 4'he;
   localparam logic [3:0] OP_INCSZ = 4'hf;

   // Bit-oriented operation codes in bits 11:10.
   localparam logic [1:0] BOP_CLR = 2'h0;
   localparam logic [1:0] BOP_SET = 2'h1;
   localparam logic [1:0] BOP_TSC = 2'h2;
   localparam logic [1:0] BOP_TSS = 2'h3;

   // Control codes in bits 7:0 of the miscellaneous group.
   localparam logic [7:0] CTL_RETURN = 8'h08;
   localparam logic [7:0] CTL_IRQ_RETURN = 8'h09;
   localparam logic [7:0] CTL_SLEEP = 8'h63;
   localparam logic [7:0] CTL_WDOG_CLR = 8'h64;

   // Literal operation codes in bits 11:8.
   localparam logic [1:0] LOP_MOVE = 2'h0;
   localparam logic [1:0] LOP_RET = 2'h1;
   localparam logic [3:0] LOP_IOR = 4'h8;
   localparam logic [3:0] LOP_AND = 4'h9;
   localparam logic [3:0] LOP_XOR = 4'ha;
   localparam logic [2:0] LOP_SUB = 3'h6;
   localparam logic [2:0] LOP_ADD = 3'h7;

   // Special file addresses.
   localparam logic [6:0] FA_TIMER0 = 7'h01;
   localparam logic [6:0] FA_PCL = 7'h02;
   localparam logic [6:0] FA_STATUS = 7'h03;
   localparam logic [6:0] FA_PORT = 7'h05;
   localparam logic [6:0] FA_PAGE_LATCH = 7'h0a;
   localparam logic [6:0] FA_IRQCTL = 7'h0b;
   localparam int unsigned IRQ_ENABLE_BIT = 7;

   // Register bus map and fields.
   localparam logic [11:0] REG_CTRL = 12'h000;
   localparam logic [11:0] REG_CORE = 12'h004;
   localparam logic [11:0] REG_PC = 12'h008;
   localparam int unsigned CTRL_RUN_BIT = 0;
   localparam int unsigned CTRL_PSA_BIT = 1;
   localparam int unsigned CTRL_WAKE_BIT = 2;
   localparam int unsigned CORE_STATUS_LSB = 8;
   localparam int unsigned CORE_SLEEP_BIT = 16;
endpackage : mcu14_pkg

// file: design/mcu14_core.sv
// Instruction decoder and executor for the 14-bit microcontroller core.
`timescale 1ns/100ps
module mcu14_core #(
   parameter int unsigned STACK_DEPTH = 8
) (
   input wire logic mclk,
   input wire logic reset,
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [11:0] paddr,
   input wire logic [31:0] pwdata,
   output logic [31:0] prdata,
   output logic pready,
   output logic pslverr,
   output logic [12:0] prog_addr,
   input wire logic [13:0] prog_data,
   input wire logic [7:0] port_pins,
   output logic [7:0] port_out,
   output logic prescaler_clear,
   output logic watchdog_clear,
   output logic osc_stop
);
   localparam int unsigned SPW = $clog2(STACK_DEPTH);
   localparam logic [1:0] LAST_PHASE = 2'(mcu14_pkg::CLOCKS_PER_CYCLE - 1);

   logic [1:0] phase;
   logic [12:0] pc;
   logic [12:0] stack [STACK_DEPTH];
   logic [SPW-1:0] sp;
   logic dummy;
   logic [7:0] w;
   mcu14_pkg::mcu14_status_s st;
   logic [7:0] file_mem [128];
   logic [7:0] pclatch;
   logic [7:0] irqctl;
   logic [7:0] pin_meta;
   logic [7:0] pin_sync;
   logic sleeping;
   logic run;
   logic psa;
   logic wake;
   logic exec;
   logic do_exec;
   logic [13:0] instr;
   logic [1:0] group;
   logic [3:0] op;
   logic dbit;
   logic [6:0] fa;
   logic [2:0] bidx;
   logic [7:0] lit;
   logic [7:0] fval;
   logic [7:0] opnd;
   logic [8:0] sum9;
   logic [4:0] sumdc;
   logic [8:0] diff9;
   logic [4:0] diffdc;
   logic [7:0] res;
   logic wr_w;
   logic wr_f;
   logic upd_z;
   logic upd_c;
   logic upd_digit;
   logic new_c;
   logic new_digit;
   logic skip;
   logic jump;
   logic push;
   logic pop;
   logic gie_set;
   logic sleep_op;
   logic wdt_op;

   // Instruction fields; memory output is sampled at the last phase.
   assign instr = prog_data;
   assign group = instr[13:12];
   assign op = instr[11:8];
   assign dbit = instr[7];
   assign fa = instr[6:0];
   assign bidx = instr[9:7];
   assign lit = instr[7:0];
   assign prog_addr = pc;
   assign exec = run && !sleeping && (phase == LAST_PHASE);
   assign do_exec = exec && !dummy;

   // File operand read; the port reads the synchronised pins.
   always_comb begin
      unique case (fa)
         mcu14_pkg::FA_PCL: fval = pc[7:0];
         mcu14_pkg::FA_STATUS: fval = {3'h0, st};
         mcu14_pkg::FA_PORT: fval = pin_sync;
         mcu14_pkg::FA_PAGE_LATCH: fval = pclatch;
         mcu14_pkg::FA_IRQCTL: fval = irqctl;
         default: fval = file_mem[fa];
      endcase
   end

   // Adder and subtractor shared by file and literal forms.
   assign opnd = (group == mcu14_pkg::GRP_LIT) ? lit : fval;
   assign sum9 = {1'b0, w} + {1'b0, opnd};
   assign sumdc = {1'b0, w[3:0]} + {1'b0, opnd[3:0]};
   assign diff9 = {1'b0, opnd} + {1'b0, ~w} + 9'h001;
   assign diffdc = {1'b0, opnd[3:0]} + {1'b0, ~w[3:0]} + 5'h01;

   // Decode and compute result, destination, flags and flow control.
   always_comb begin
      res = 8'h00;
      wr_w = 1'b0;
      wr_f = 1'b0;
      upd_z = 1'b0;
      upd_c = 1'b0;
      upd_digit = 1'b0;
      new_c = st.c;
      new_digit = st.digit_carry;
      skip = 1'b0;
      jump = 1'b0;
      push = 1'b0;
      pop = 1'b0;
      gie_set = 1'b0;
      sleep_op = 1'b0;
      wdt_op = 1'b0;
      unique case (group)
         mcu14_pkg::GRP_BYTE: begin
            wr_w = !dbit;
            wr_f = dbit;
            upd_z = 1'b1;
            unique case (op)
               mcu14_pkg::OP_MISC: begin
                  res = w;
                  wr_w = 1'b0;
                  upd_z = 1'b0;
                  if (!dbit) begin
                     unique case (lit)
                        mcu14_pkg::CTL_RETURN: pop = 1'b1;
                        mcu14_pkg::CTL_IRQ_RETURN: begin
                           pop = 1'b1;
                           gie_set = 1'b1;
                        end
                        mcu14_pkg::CTL_SLEEP: sleep_op = 1'b1;
                        mcu14_pkg::CTL_WDOG_CLR: wdt_op = 1'b1;
                        default: pop = 1'b0; // No-operation
                     endcase
                  end
               end
               mcu14_pkg::OP_CLR: res = 8'h00;
               mcu14_pkg::OP_SUB: begin
                  res = diff9[7:0];
                  {upd_c, upd_digit} = 2'h3;
                  new_c = diff9[8];
                  new_digit = diffdc[4];
               end
               mcu14_pkg::OP_DEC: res = fval - 8'h01;
               mcu14_pkg::OP_IOR: res = w | fval;
               mcu14_pkg::OP_AND: res = w & fval;
               mcu14_pkg::OP_XOR: res = w ^ fval;
               mcu14_pkg::OP_ADD: begin
                  res = sum9[7:0];
                  {upd_c, upd_digit} = 2'h3;
                  new_c = sum9[8];
                  new_digit = sumdc[4];
               end
               mcu14_pkg::OP_MOVE: res = fval;
               mcu14_pkg::OP_COMPL: res = ~fval;
               mcu14_pkg::OP_INC: res = fval + 8'h01;
               mcu14_pkg::OP_DECSZ: begin
                  res = fval - 8'h01;
                  upd_z = 1'b0;
                  skip = (res == 8'h00);
               end
               mcu14_pkg::OP_ROR: begin
                  res = {st.c, fval[7:1]};
                  upd_z = 1'b0;
                  upd_c = 1'b1;
                  new_c = fval[0];
               end
               mcu14_pkg::OP_ROL: begin
                  res = {fval[6:0], st.c};
                  upd_z = 1'b0;
                  upd_c = 1'b1;
                  new_c = fval[7];
               end
               mcu14_pkg::OP_SWAP: begin
                  res = {fval[3:0], fval[7:4]};
                  upd_z = 1'b0;
               end
               mcu14_pkg::OP_INCSZ: begin
                  res = fval + 8'h01;
                  upd_z = 1'b0;
                  skip = (res == 8'h00);
               end
            endcase
         end
         mcu14_pkg::GRP_BIT: begin
            res = fval;
            res[bidx] = (op[3:2] == mcu14_pkg::BOP_SET);
            wr_f = !op[3];
            if (op[3]) begin
               // Skip when the tested bit matches the form.
               skip = (fval[bidx] == (op[3:2] == mcu14_pkg::BOP_TSS));
            end
         end
         mcu14_pkg::GRP_JUMP: begin
            jump = 1'b1;
            push = !instr[11];
         end
         mcu14_pkg::GRP_LIT: begin
            wr_w = 1'b1;
            upd_z = 1'b1;
            if (op[3:2] == mcu14_pkg::LOP_MOVE) begin
               res = lit;
               upd_z = 1'b0;
            end else if (op[3:2] == mcu14_pkg::LOP_RET) begin
               res = lit;
               upd_z = 1'b0;
               pop = 1'b1;
            end else if (op == mcu14_pkg::LOP_IOR) begin
               res = w | lit;
            end else if (op == mcu14_pkg::LOP_AND) begin
               res = w & lit;
            end else if (op == mcu14_pkg::LOP_XOR) begin
               res = w ^ lit;
            end else if (op[3:1] == mcu14_pkg::LOP_SUB) begin
               res = diff9[7:0];
               {upd_c, upd_digit} = 2'h3;
               new_c = diff9[8];
               new_digit = diffdc[4];
            end else if (op[3:1] == mcu14_pkg::LOP_ADD) begin
               res = sum9[7:0];
               {upd_c, upd_digit} = 2'h3;
               new_c = sum9[8];
               new_digit = sumdc[4];
            end else begin
               wr_w = 1'b0;
               upd_z = 1'b0;
            end
         end
      endcase
   end

   // Oscillator phase counter; four clocks make one instruction cycle.
   always_ff @(posedge mclk) begin
      if (reset || !run || sleeping) begin
         phase <= 2'h0;
      end else begin
         phase <= phase + 2'h1;
      end
   end

   // Program counter, return stack and the dummy second cycle.
   always_ff @(posedge mclk) begin
      if (reset) begin
         pc <= mcu14_pkg::RESET_PC;
         sp <= '0;
         dummy <= 1'b0;
      end else if (exec) begin
         dummy <= 1'b0;
         if (!dummy) begin
            pc <= pc + 13'h0001;
            if (jump) begin
               pc <= {pclatch[4:3], instr[10:0]};
               dummy <= 1'b1;
               if (push) begin
                  stack[sp] <= pc + 13'h0001;
                  sp <= sp + 1'b1;
               end
            end else if (pop) begin
               pc <= stack[sp - 1'b1];
               sp <= sp - 1'b1;
               dummy <= 1'b1;
            end else if (skip) begin
               pc <= pc + 13'h0002;
               dummy <= 1'b1;
            end else if (wr_f && fa == mcu14_pkg::FA_PCL) begin
               pc <= {pclatch[4:0], res};
               dummy <= 1'b1;
            end
         end
      end
   end

   // Working register.
   always_ff @(posedge mclk) begin
      if (reset) begin
         w <= 8'h00;
      end else if (do_exec && wr_w) begin
         w <= res;
      end
   end

   // Status flags; flag updates take priority over a direct write.
   always_ff @(posedge mclk) begin
      if (reset) begin
         st <= mcu14_pkg::STATUS_RESET;
      end else if (do_exec) begin
         if (wr_f && fa == mcu14_pkg::FA_STATUS) begin
            {st.z, st.digit_carry, st.c} <= res[2:0];
         end
         if (upd_z) begin
            st.z <= (res == 8'h00);
         end
         if (upd_c) begin
            st.c <= new_c;
         end
         if (upd_digit) begin
            st.digit_carry <= new_digit;
         end
         if (wdt_op) begin
            st.timeout_flag <= 1'b1;
            st.powerdown_flag <= 1'b1;
         end
         if (sleep_op) begin
            st.timeout_flag <= 1'b1;
            st.powerdown_flag <= 1'b0;
         end
      end
   end

   // General file memory.
   always_ff @(posedge mclk) begin
      if (do_exec && wr_f && fa != mcu14_pkg::FA_PCL &&
          fa != mcu14_pkg::FA_STATUS && fa != mcu14_pkg::FA_PORT &&
          fa != mcu14_pkg::FA_PAGE_LATCH && fa != mcu14_pkg::FA_IRQCTL) begin
         file_mem[fa] <= res;
      end
   end

   // Special file registers: page latch, interrupt control, port latch.
   always_ff @(posedge mclk) begin
      if (reset) begin
         pclatch <= 8'h00;
         irqctl <= 8'h00;
         port_out <= 8'h00;
      end else if (do_exec) begin
         if (wr_f && fa == mcu14_pkg::FA_PAGE_LATCH) begin
            pclatch <= res;
         end
         if (wr_f && fa == mcu14_pkg::FA_IRQCTL) begin
            irqctl <= res;
         end
         if (gie_set) begin
            irqctl[mcu14_pkg::IRQ_ENABLE_BIT] <= 1'b1;
         end
         if (wr_f && fa == mcu14_pkg::FA_PORT) begin
            port_out <= res;
         end
      end
   end

   // One-cycle pulses to the timer prescaler and the watchdog.
   always_ff @(posedge mclk) begin
      if (reset) begin
         prescaler_clear <= 1'b0;
         watchdog_clear <= 1'b0;
      end else begin
         prescaler_clear <= do_exec && wr_f && psa &&
                            fa == mcu14_pkg::FA_TIMER0;
         watchdog_clear <= do_exec && (wdt_op || sleep_op);
      end
   end

   // Standby state; a sleep in the same cycle as a wake request wins.
   always_ff @(posedge mclk) begin
      if (reset) begin
         sleeping <= 1'b0;
      end else if (do_exec && sleep_op) begin
         sleeping <= 1'b1;
      end else if (wake) begin
         sleeping <= 1'b0;
      end
   end
   assign osc_stop = sleeping;

   // Two-flop synchroniser for the port pins.
   always_ff @(posedge mclk) begin
      if (reset) begin
         pin_meta <= 8'h00;
         pin_sync <= 8'h00;
      end else begin
         pin_meta <= port_pins;
         pin_sync <= pin_meta;
      end
   end

   // Bus slave: control writes taken in the access cycle, read data captured in the setup cycle.
   assign pready = 1'b1;
   always_ff @(posedge mclk) begin
      if (reset) begin
         run <= 1'b0;
         psa <= 1'b0;
         wake <= 1'b0;
         prdata <= 32'h0000_0000;
         pslverr <= 1'b0;
      end else begin
         wake <= 1'b0;
         if (psel && !penable) begin
            prdata <= 32'h0000_0000;
            pslverr <= 1'b0;
            unique case (paddr)
               mcu14_pkg::REG_CTRL: begin
                  prdata[mcu14_pkg::CTRL_RUN_BIT] <= run;
                  prdata[mcu14_pkg::CTRL_PSA_BIT] <= psa;
               end
               mcu14_pkg::REG_CORE: begin
                  prdata[7:0] <= w;
                  prdata[mcu14_pkg::CORE_STATUS_LSB +: 5] <= st;
                  prdata[mcu14_pkg::CORE_SLEEP_BIT] <= sleeping;
               end
               mcu14_pkg::REG_PC: prdata[12:0] <= pc;
               default: pslverr <= 1'b1;
            endcase
         end
         if (psel && penable && pwrite && paddr == mcu14_pkg::REG_CTRL) begin
            run <= pwdata[mcu14_pkg::CTRL_RUN_BIT];
            psa <= pwdata[mcu14_pkg::CTRL_PSA_BIT];
            wake <= pwdata[mcu14_pkg::CTRL_WAKE_BIT];
         end
      end
   end
endmodule : mcu14_core

// file: tb/mcu14_core_asserts.sv
// Port-level checks for the instruction core, bound to its top module.
`timescale 1ns/100ps
module mcu14_core_asserts (
   input wire logic mclk,
   input wire logic reset,
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [11:0] paddr,
   input wire logic [31:0] pwdata,
   input wire logic [31:0] prdata,
   input wire logic pready,
   input wire logic pslverr,
   input wire logic [12:0] prog_addr,
   input wire logic [13:0] prog_data,
   input wire logic [7:0] port_pins,
   input wire logic [7:0] port_out,
   input wire logic prescaler_clear,
   input wire logic watchdog_clear,
   input wire logic osc_stop
);
   default clocking cb @(posedge mclk);
   endclocking
   default disable iff (reset);
   logic wdc_d;
   logic mapped;
   logic wake_wr;
   logic wake_d;
   // Delayed watchdog pulse and wake write; sleep ends two edges on.
   always_ff @(posedge mclk) begin
      wdc_d <= watchdog_clear;
      wake_d <= wake_wr;
   end
   // Register decode and the wake request as seen on the bus.
   assign mapped = paddr == mcu14_pkg::REG_CTRL ||
      paddr == mcu14_pkg::REG_CORE || paddr == mcu14_pkg::REG_PC;
   assign wake_wr = psel && penable && pwrite &&
      paddr == mcu14_pkg::REG_CTRL && pwdata[mcu14_pkg::CTRL_WAKE_BIT];
   sequence s_pc_step;
      $changed(prog_addr);
   endsequence
   sequence s_pc_hold;
      $stable(prog_addr) [*3];
   endsequence
   a_pc_holds_cycle:
      assert property (s_pc_step |=> s_pc_hold)
      else $error("program address moved inside a cycle");
   a_port_at_exec:
      assert property ($changed(port_out) |-> s_pc_step)
      else $error("port write off the instruction boundary");
   a_wdt_single:
      assert property (watchdog_clear |=> !watchdog_clear [*3])
      else $error("watchdog clear pulse too long");
   a_wdt_at_exec:
      assert property (watchdog_clear |-> s_pc_step)
      else $error("watchdog clear not at instruction end");
   a_psc_single:
      assert property (prescaler_clear |=> !prescaler_clear [*3])
      else $error("prescaler clear pulse too long");
   a_psc_at_exec:
      assert property (prescaler_clear |-> s_pc_step)
      else $error("prescaler clear not at instruction end");
   a_sleep_clears_wdt:
      assert property ($rose(osc_stop) |-> ##[0:1] (watchdog_clear || wdc_d))
      else $error("sleep entered without watchdog clear");
   a_sleep_holds:
      assert property (osc_stop && !wake_wr && !wake_d |=> osc_stop)
      else $error("sleep left without a wake write");
   a_sleep_pc_frozen:
      assert property (osc_stop [*3] |-> $stable(prog_addr))
      else $error("program address moved while asleep");
   a_bus_ready:
      assert property (pready)
      else $error("bus ready low");
   a_bus_unmapped:
      assert property (psel && penable && !mapped |->
         pslverr && (pwrite || prdata == 32'h0))
      else $error("unmapped access not refused");
   a_bus_mapped:
      assert property (psel && penable && mapped |-> !pslverr)
      else $error("mapped access refused");
endmodule : mcu14_core_asserts

bind mcu14_core mcu14_core_asserts u_mcu14_core_asserts (
   .mclk(mclk), .reset(reset), .psel(psel), .penable(penable),
   .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
   .pready(pready), .pslverr(pslverr), .prog_addr(prog_addr),
   .prog_data(prog_data), .port_pins(port_pins), .port_out(port_out),
   .prescaler_clear(prescaler_clear), .watchdog_clear(watchdog_clear),
   .osc_stop(osc_stop)
);

// file: tb/mcu14_progmem.sv
// Program memory model that feeds instruction words to the core.
`timescale 1ns/100ps
module mcu14_progmem #(
   parameter int LATENCY = 2
) (
   input wire logic mclk,
   input wire logic [12:0] prog_addr,
   output logic [13:0] prog_data
);
   logic [13:0] mem [128];
   logic [13:0] pipe [3];
   // Read pipeline; the word shows up LATENCY clocks after the address.
   always_ff @(posedge mclk) begin
      pipe[0] <= mem[prog_addr[6:0]];
      pipe[1] <= pipe[0];
      pipe[2] <= pipe[1];
   end
   assign prog_data = pipe[LATENCY-1];
endmodule : mcu14_progmem

// file: tb/testbench.sv
// Self-checking bench: register access and a program run on the core.
`timescale 1ns/100ps
module testbench;
   localparam int NPROG = 53;
   localparam logic [13:0] PROG [NPROG] = '{
      14'h300f, 14'h3e01, 14'h0085, 14'h00a0, 14'h0803, 14'h391f,
      14'h0085, 14'h3c10, 14'h0085, 14'h0803, 14'h391f, 14'h0085,
      14'h3a18, 14'h0803, 14'h391f, 14'h0085, 14'h09a0, 14'h0d20,
      14'h0085, 14'h0c20, 14'h0085, 14'h3001, 14'h00a1, 14'h0ba1,
      14'h0085, 14'h3055, 14'h0085, 14'h1821, 14'h3099, 14'h1c21,
      14'h3066, 14'h0085, 14'h17a1, 14'h0821, 14'h0085, 14'h13a1,
      14'h0a21, 14'h0085, 14'h018a, 14'h2040, 14'h0085, 14'h2041,
      14'h080b, 14'h3980, 14'h0085, 14'h0805, 14'h0085, 14'h0e20,
      14'h0085, 14'h0081, 14'h0064, 14'h0063, 14'h2842};
   localparam logic [7:0] MARKS [19] = '{8'h10, 8'h1a, 8'hf6, 8'h18,
      8'h1c, 8'hde, 8'hf7, 8'h55, 8'h66, 8'h80, 8'h01, 8'h77, 8'h80,
      8'h3c, 8'hfe, 8'hed, 8'h00, 8'h17, 8'h0f};
   // Instruction cycles between port writes; zero spans the sleep.
   localparam int GAPS [18] = '{4, 2, 3, 4, 3, 2, 6, 5, 3, 3, 6, 7, 2, 2,
      0, 2, 2, 9};
   // Code run after the wake: file forms of arithmetic and logic.
   localparam logic [13:0] WAKE_PROG [16] = '{14'h0720, 14'h0085,
      14'h0220, 14'h0585, 14'h0803, 14'h0085, 14'h0100, 14'h0420,
      14'h0620, 14'h03a1, 14'h0fa1, 14'h0085, 14'h0821, 14'h3a0f,
      14'h0085, 14'h2851};
   localparam logic [11:0] A_CTRL = mcu14_pkg::REG_CTRL;
   localparam logic [11:0] A_CORE = mcu14_pkg::REG_CORE;
   localparam logic [11:0] A_PC = mcu14_pkg::REG_PC;
   logic mclk;
   logic reset = 1'b1;
   logic psel = 1'b0;
   logic penable = 1'b0;
   logic pwrite = 1'b0;
   logic [11:0] paddr = 12'h000;
   logic [31:0] pwdata = 32'h0;
   logic [31:0] prdata;
   logic pready;
   logic pslverr;
   logic [12:0] prog_addr;
   logic [13:0] prog_data;
   logic [7:0] port_pins = 8'h3c;
   logic [7:0] port_out;
   logic prescaler_clear;
   logic watchdog_clear;
   logic osc_stop;
   logic [31:0] rd;
   logic er;
   logic [7:0] last_port = 8'h00;
   logic [7:0] mv [$];
   int mt [$];
   int n_errors = 0;
   int tests_run = 0;
   int cyc = 0;
   int n_wdc = 0;
   int n_psc = 0;

   mcu14_core u_mcu14_core (.mclk(mclk), .reset(reset), .psel(psel),
      .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
      .prdata(prdata), .pready(pready), .pslverr(pslverr),
      .prog_addr(prog_addr), .prog_data(prog_data), .port_pins(port_pins),
      .port_out(port_out), .prescaler_clear(prescaler_clear),
      .watchdog_clear(watchdog_clear), .osc_stop(osc_stop));
   mcu14_progmem u_mcu14_progmem (.mclk(mclk), .prog_addr(prog_addr),
      .prog_data(prog_data));

   // Free-running clock at 50 MHz.
   initial begin
      mclk = 1'b0;
      forever #10 mclk = ~mclk;
   end

   // Logs each change of the port latch with its clock count, and pulses.
   always @(posedge mclk) begin
      cyc <= cyc + 1;
      n_wdc <= n_wdc + (watchdog_clear === 1'b1);
      n_psc <= n_psc + (prescaler_clear === 1'b1);
      if (reset === 1'b0 && port_out !== last_port) begin
         mv.push_back(port_out);
         mt.push_back(cyc);
         last_port <= port_out;
      end
   end

   task automatic check(input string what, input logic [31:0] exp,
         input logic [31:0] got);
      tests_run++;
      if (got !== exp) begin
         n_errors++;
         $display("wrong value %s: expected %h, seen %h", what, exp, got);
      end
   endtask : check

   // One bus transfer; read data and error are taken at the ready edge.
   task automatic apb(input logic w, input logic [11:0] a,
         input logic [31:0] d);
      int n;
      n = 0;
      @(posedge mclk);
      psel <= 1'b1;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge mclk);
      penable <= 1'b1;
      do begin
         @(posedge mclk);
         n++;
      end while (pready !== 1'b1 && n < 50);
      if (n >= 50) n_errors++;
      rd = prdata;
      er = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
   endtask : apb

   // Value of one port write and its spacing from the previous one.
   task automatic mark(input int i);
      check("port value", 32'(MARKS[i]), 32'(mv[i]));
      if (i > 0 && GAPS[i-1] > 0) begin
         check("write spacing", 32'(GAPS[i-1] *
            mcu14_pkg::CLOCKS_PER_CYCLE), 32'(mt[i] - mt[i-1]));
      end
   endtask : mark

   task automatic finish_test;
      $display("checks %0d, mismatches %0d", tests_run, n_errors);
      if (n_errors == 0 && tests_run > 0) begin
         $display("DONE - PASS");
      end else begin
         $display("DONE - FAIL");
      end
      $finish;
   endtask : finish_test

   // Cuts a hang short.
   initial begin
      repeat (5000) @(posedge mclk);
      n_errors++;
      $display("watchdog ran out");
      finish_test();
   end

   // Main sequence.
   initial begin
      for (int i = 0; i < 128; i++) begin
         u_mcu14_progmem.mem[i] = (i < NPROG) ? PROG[i] : 14'h0000;
      end
      u_mcu14_progmem.mem[64] = 14'h3477;
      u_mcu14_progmem.mem[65] = 14'h0009;
      for (int i = 0; i < 16; i++) begin
         u_mcu14_progmem.mem[66+i] = WAKE_PROG[i];
      end
      repeat (3) @(posedge mclk);
      reset <= 1'b0;
      apb(1'b0, A_CTRL, 32'h0);
      check("ctrl reset", 32'h0, rd);
      apb(1'b1, A_CORE, 32'hffffffff);
      check("core write error", 32'h0, 32'(er));
      apb(1'b0, A_CORE, 32'h0);
      check("core reset", 32'(mcu14_pkg::STATUS_RESET) <<
         mcu14_pkg::CORE_STATUS_LSB, rd);
      apb(1'b0, A_PC, 32'h0);
      check("pc reset", 32'h0, rd);
      apb(1'b0, 12'h00c, 32'h0);
      check("unmapped error", 32'h1, 32'(er));
      check("unmapped data", 32'h0, rd);
      $display("test register map done");
      apb(1'b1, A_CTRL, (32'h1 << mcu14_pkg::CTRL_RUN_BIT) |
         (32'h1 << mcu14_pkg::CTRL_PSA_BIT));
      for (int i = 0; i < 3000 && osc_stop !== 1'b1; i++) @(posedge mclk);
      @(posedge mclk); // Lets the last pulse count settle.
      check("write count", 32'd15, 32'(mv.size()));
      mark(0);
      mark(1);
      mark(2);
      mark(3);
      mark(4);
      mark(5);
      mark(6);
      mark(7);
      mark(8);
      mark(9);
      mark(10);
      mark(11);
      mark(12);
      mark(13);
      mark(14);
      check("prescaler pulses", 32'd1, 32'(n_psc));
      check("watchdog pulses", 32'd2, 32'(n_wdc));
      check("asleep", 32'h1, 32'(osc_stop));
      apb(1'b0, A_CORE, 32'h0);
      check("core asleep", (32'h1 << mcu14_pkg::CORE_SLEEP_BIT) |
         (32'h11 << mcu14_pkg::CORE_STATUS_LSB) | 32'hfe, rd);
      apb(1'b0, A_PC, 32'h0);
      check("pc asleep", 32'd52, rd);
      $display("test program done");
      apb(1'b1, A_CTRL, (32'h1 << mcu14_pkg::CTRL_RUN_BIT) |
         (32'h1 << mcu14_pkg::CTRL_WAKE_BIT));
      repeat (8) @(posedge mclk);
      check("awake", 32'h0, 32'(osc_stop));
      apb(1'b0, A_CTRL, 32'h0);
      check("ctrl after wake", 32'h1, rd);
      for (int i = 0; i < 400 && mv.size() < 19; i++) @(posedge mclk);
      repeat (8) @(posedge mclk);
      check("wake write count", 32'd19, 32'(mv.size()));
      mark(15);
      mark(16);
      mark(17);
      mark(18);
      check("watchdog idle", 32'd2, 32'(n_wdc));
      $display("test wake done");
      finish_test();
   end
endmodule : testbench
